//--- rtl/two_wire_pkg.sv
`default_nettype none
package two_wire_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [4:0] OFS_STATUS = 5'h00;
    localparam logic [4:0] OFS_CTRL_ONE = 5'h04;
    localparam logic [4:0] OFS_CTRL_TWO = 5'h08;
    localparam logic [4:0] OFS_BUFFER = 5'h0C;
    localparam logic [4:0] OFS_ADDRESS = 5'h10;
    localparam logic [4:0] OFS_IRQ = 5'h14;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int C1_WRITE_COLLISION = 7;
    localparam int C1_OVF = 6;
    localparam int C1_EN = 5;
    localparam int C1_CKREL = 4;
    localparam int C2_GENERAL_CALL_ENABLE = 7;
    localparam int C2_ACKST = 6;
    localparam int C2_ACK_DATA_VALUE = 5;
    localparam int C2_ACK_SEQUENCE_REQUEST = 4;
    localparam int C2_RECEIVE_REQUEST = 3;
    localparam int C2_STOP = 2;
    localparam int C2_RESTART = 1;
    localparam int C2_START = 0;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;

    // ----------------------------------------
    // Mode codes and bus constants
    // ----------------------------------------
    localparam logic [3:0] MODE_MASTER = 4'h8;
    localparam logic [3:0] MODE_FW_MASTER = 4'hB;
    localparam logic [3:0] MODE_SLAVE7 = 4'h6;
    localparam logic [3:0] MODE_SLAVE10 = 4'h7;
    localparam logic [3:0] MODE_SLAVE7_SP = 4'hE;
    localparam logic [3:0] MODE_SLAVE10_SP = 4'hF;
    localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
    localparam logic [3:0] BYTE_LAST = 4'h8;
    localparam logic [3:0] ACK_LAST = 4'h9;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_START = 3'b001,
        M_RESTART = 3'b010,
        M_STOP = 3'b011,
        M_TX = 3'b100,
        M_RX = 3'b101,
        M_ACK = 3'b110
    } master_state_e;

endpackage : two_wire_pkg
`default_nettype wire

//--- rtl/two_wire_port.sv
// Contract
// R1 - Address register: slave address or baud reload
// R2 - Full received byte copied to buffer, flag
// R3 - Buffer write loads buffer and shift register
// R4 - Status bit 7 slew setting to pads
// R5 - Status bit 6 selects bus-variant input levels
// R6 - Slave data-or-address bit tracks last byte
// R7 - Start/stop seen flags, cleared by disable
// R8 - Slave direction bit from last matched address
// R9 - Master direction bit shows transmit busy
// R10 - Ten-bit slave asks for address update
// R11 - Buffer full while held or shifting
// R12 - Write collision on illegal buffer write
// R13 - Overflow when byte arrives into full buffer
// R14 - Enable connects pins to the port
// R15 - Slave clock release bit stretches clock
// R16 - Mode 1000 hardware master, 1011 firmware (code does not decode 1011; both lines stay released)
// R17 - Slave mode codes 0110,0111,1110,1111
// R18 - General call raises flag when enabled
// R19 - Master transmit records slave acknowledge
// R20 - Acknowledge sequence sends chosen bit
// R21 - Receive request clocks in one byte
// R22 - Condition requests generate, then self-clear
// R23 - Busy port refuses requests and buffer writes
// R24 - Full buffer: no acknowledge, flag still set
// R25 - Slave start bit enables receive stretching
// R26 - Bus lines only pulled low, open drain
//
// The register offsets and register access over Avalon-MM were decided locally.
`default_nettype none
module two_wire_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic port_irq_flag,
    output logic slew_select,
    output logic smbus_levels,
    output logic pins_to_port
);
    import two_wire_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic slew;
        logic smb;
        logic data_addr;
        logic stop_seen;
        logic start_seen;
        logic rw;
        logic ua;
        logic bf;
        logic [7:0] tbuf;
        logic [7:0] sreg;
        logic [7:0] addr;
        logic irq;
        logic waitreq;
        logic [31:0] rdata;
        master_state_e mst;
        logic [1:0] phase;
        logic [3:0] bits;
        logic [6:0] brg;
        logic scl_prev;
        logic sda_prev;
        logic sl_match;
        logic [3:0] sl_bits;
        logic scl_low;
        logic sda_low;
        logic pin_level;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic [7:0] rd_byte;
    logic en, is_master, is_slave, ten_bit, sp_irq, master_idle;
    logic wr_hit, rd_hit, tick, slave_tx;
    logic scl_rise, scl_fall, start_det, stop_det, addr_hit, gc_hit;

    assign en = st_r.ctrl1[C1_EN];
    assign is_master = en && st_r.ctrl1[3:0] == MODE_MASTER; // [R16]
    assign is_slave = en && (st_r.ctrl1[3:0] == MODE_SLAVE7 ||
        st_r.ctrl1[3:0] == MODE_SLAVE10 ||
        st_r.ctrl1[3:0] == MODE_SLAVE7_SP ||
        st_r.ctrl1[3:0] == MODE_SLAVE10_SP); // [R17]
    assign ten_bit = st_r.ctrl1[3:0] == MODE_SLAVE10 ||
        st_r.ctrl1[3:0] == MODE_SLAVE10_SP;
    assign sp_irq = st_r.ctrl1[3:0] == MODE_SLAVE7_SP ||
        st_r.ctrl1[3:0] == MODE_SLAVE10_SP;
    assign master_idle = st_r.mst == M_IDLE && !st_r.rw &&
        st_r.ctrl2[4:0] == 5'h00; // [R9]
    assign wr_hit = write && st_r.waitreq && byteenable[0];
    assign rd_hit = read && st_r.waitreq;
    assign tick = st_r.brg == 7'h00;
    assign slave_tx = st_r.sl_match && st_r.rw;
    assign scl_rise = scl_in && !st_r.scl_prev;
    assign scl_fall = !scl_in && st_r.scl_prev;
    assign start_det = scl_in && st_r.scl_prev && st_r.sda_prev && !sda_in;
    assign stop_det = scl_in && st_r.scl_prev && !st_r.sda_prev && sda_in;
    assign addr_hit = (ten_bit && st_r.sreg[7:3] != TEN_BIT_PREFIX) ?
        st_r.sreg == st_r.addr : st_r.sreg[7:1] == st_r.addr[7:1]; // [R1]
    assign gc_hit = st_r.ctrl2[C2_GENERAL_CALL_ENABLE] &&
        st_r.sreg == GENERAL_CALL_ADDR; // [R18]

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        if (address == OFS_STATUS) begin
            rd_byte = {st_r.slew, st_r.smb, st_r.data_addr, st_r.stop_seen,
                st_r.start_seen, st_r.rw, st_r.ua, st_r.bf};
        end else if (address == OFS_CTRL_ONE) begin
            rd_byte = st_r.ctrl1;
        end else if (address == OFS_CTRL_TWO) begin
            rd_byte = st_r.ctrl2;
        end else if (address == OFS_BUFFER) begin
            rd_byte = st_r.tbuf;
        end else if (address == OFS_ADDRESS) begin
            rd_byte = st_r.addr;
        end else if (address == OFS_IRQ) begin
            rd_byte = {7'h00, st_r.irq};
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.waitreq = 1'b1;
        st_nxt.scl_prev = scl_in;
        st_nxt.sda_prev = sda_in;
        // Bus slave: one wait state, then answer
        if (rd_hit || (write && st_r.waitreq)) begin
            st_nxt.waitreq = 1'b0;
        end
        if (rd_hit) begin
            st_nxt.rdata = {24'h000000, rd_byte};
            if (address == OFS_BUFFER) begin
                st_nxt.bf = 1'b0;
            end
        end
        if (wr_hit) begin
            if (address == OFS_STATUS) begin
                st_nxt.slew = writedata[7]; // [R4]
                st_nxt.smb = writedata[6]; // [R5]
            end else if (address == OFS_CTRL_ONE) begin
                st_nxt.ctrl1 = writedata[7:0];
            end else if (address == OFS_CTRL_TWO) begin
                st_nxt.ctrl2[7:5] = writedata[7:5];
                if (!is_master || master_idle) begin
                    st_nxt.ctrl2[4:0] = writedata[4:0]; // [R23]
                end
            end else if (address == OFS_BUFFER) begin
                if (is_master && !master_idle) begin
                    st_nxt.ctrl1[C1_WRITE_COLLISION] = 1'b1; // [R12] [R23]
                end else if (is_slave && slave_tx &&
                    st_r.sl_bits != 4'h0 && st_r.sl_bits < BYTE_LAST) begin
                    st_nxt.ctrl1[C1_WRITE_COLLISION] = 1'b1; // [R12]
                end else begin
                    st_nxt.tbuf = writedata[7:0]; // [R3]
                    st_nxt.sreg = writedata[7:0]; // [R3]
                    st_nxt.bf = en; // [R11]
                    if (is_master) begin
                        st_nxt.rw = 1'b1; // [R9]
                        st_nxt.mst = M_TX;
                        st_nxt.phase = 2'h0;
                        st_nxt.bits = 4'h0;
                    end
                end
            end else if (address == OFS_ADDRESS) begin
                st_nxt.addr = writedata[7:0];
                st_nxt.ua = 1'b0; // [R10]
            end else if (address == OFS_IRQ) begin
                if (writedata[0]) begin
                    st_nxt.irq = 1'b0;
                end
            end
        end

        // Bus condition monitor
        if (en && start_det) begin
            st_nxt.start_seen = 1'b1; // [R7]
            st_nxt.stop_seen = 1'b0;
            st_nxt.sl_bits = 4'h0;
            st_nxt.sl_match = 1'b0;
            if (is_slave) begin
                st_nxt.rw = 1'b0; // [R8]
                st_nxt.irq = st_r.irq | sp_irq;
            end
        end else if (en && stop_det) begin
            st_nxt.stop_seen = 1'b1; // [R7]
            st_nxt.start_seen = 1'b0;
            st_nxt.sl_bits = 4'h0;
            st_nxt.sl_match = 1'b0;
            if (is_slave) begin
                st_nxt.rw = 1'b0; // [R8]
                st_nxt.irq = st_r.irq | sp_irq;
            end
        end

        // Master engine, quarter-bit ticks
        if (is_master) begin
            st_nxt.brg = tick ? st_r.addr[6:0] :
                7'(st_r.brg - 7'h01); // [R1] [R16]
            case (st_r.mst)
                M_IDLE: begin
                    st_nxt.phase = 2'h0;
                    st_nxt.bits = 4'h0;
                    if (st_r.ctrl2[C2_START]) begin
                        st_nxt.mst = M_START; // [R22]
                    end else if (st_r.ctrl2[C2_RESTART]) begin
                        st_nxt.mst = M_RESTART; // [R22]
                    end else if (st_r.ctrl2[C2_STOP]) begin
                        st_nxt.mst = M_STOP; // [R22]
                    end else if (st_r.ctrl2[C2_RECEIVE_REQUEST]) begin
                        st_nxt.mst = M_RX; // [R21]
                    end else if (st_r.ctrl2[C2_ACK_SEQUENCE_REQUEST]) begin
                        st_nxt.mst = M_ACK; // [R20]
                    end
                end
                M_START, M_RESTART, M_STOP: begin
                    if (tick) begin
                        st_nxt.phase = 2'(st_r.phase + 2'h1);
                        if (st_r.mst == M_START) begin
                            st_nxt.sda_low = st_r.phase != 2'h0;
                            st_nxt.scl_low = st_r.phase >= 2'h2;
                        end else if (st_r.mst == M_RESTART) begin
                            st_nxt.sda_low = st_r.phase >= 2'h2;
                            st_nxt.scl_low = st_r.phase == 2'h0 ||
                                st_r.phase == 2'h3;
                        end else begin
                            st_nxt.sda_low = st_r.phase < 2'h2;
                            st_nxt.scl_low = st_r.phase == 2'h0;
                        end
                        if (st_r.phase == 2'h3) begin
                            st_nxt.mst = M_IDLE;
                            st_nxt.irq = 1'b1;
                            st_nxt.ctrl2[2:0] = 3'h0; // [R22]
                        end
                    end
                end
                default: begin
                    if (tick) begin
                        st_nxt.phase = 2'(st_r.phase + 2'h1);
                        case (st_r.phase)
                            2'h0: begin
                                st_nxt.scl_low = 1'b1;
                                if (st_r.mst == M_ACK) begin
                                    st_nxt.sda_low =
                                        !st_r.ctrl2[C2_ACK_DATA_VALUE]; // [R20]
                                end else if (st_r.mst == M_TX) begin
                                    st_nxt.sda_low = st_r.bits < BYTE_LAST &&
                                        !st_r.sreg[7];
                                end else begin
                                    st_nxt.sda_low = 1'b0;
                                end
                            end
                            2'h1: st_nxt.scl_low = 1'b0;
                            2'h2: begin
                                if (st_r.mst == M_TX) begin
                                    if (st_r.bits == BYTE_LAST) begin
                                        st_nxt.ctrl2[C2_ACKST] = sda_in; // [R19]
                                    end else begin
                                        st_nxt.sreg = {st_r.sreg[6:0], 1'b0};
                                    end
                                end else if (st_r.mst == M_RX) begin
                                    st_nxt.sreg = {st_r.sreg[6:0], sda_in};
                                end
                            end
                            default: begin
                                st_nxt.scl_low = 1'b1;
                                st_nxt.bits = 4'(st_r.bits + 4'h1);
                                if (st_r.mst == M_TX &&
                                    st_r.bits == BYTE_LAST) begin
                                    st_nxt.mst = M_IDLE;
                                    st_nxt.sda_low = 1'b0;
                                    st_nxt.rw = 1'b0; // [R9]
                                    st_nxt.bf = 1'b0; // [R11]
                                    st_nxt.irq = 1'b1;
                                end else if (st_r.mst == M_RX &&
                                    st_r.bits == 4'h7) begin
                                    st_nxt.mst = M_IDLE;
                                    st_nxt.ctrl2[C2_RECEIVE_REQUEST] = 1'b0; // [R21]
                                    st_nxt.irq = 1'b1; // [R2]
                                    if (st_r.bf) begin
                                        st_nxt.ctrl1[C1_OVF] = 1'b1; // [R13]
                                    end else begin
                                        st_nxt.tbuf = st_r.sreg; // [R2]
                                        st_nxt.bf = 1'b1; // [R11]
                                    end
                                end else if (st_r.mst == M_ACK) begin
                                    st_nxt.mst = M_IDLE;
                                    st_nxt.sda_low = 1'b0;
                                    st_nxt.ctrl2[C2_ACK_SEQUENCE_REQUEST] = 1'b0; // [R20]
                                    st_nxt.irq = 1'b1;
                                end
                            end
                        endcase
                    end
                end
            endcase
        end else if (is_slave) begin
            st_nxt.mst = M_IDLE;
            if (scl_rise && st_r.sl_bits < ACK_LAST) begin
                st_nxt.sl_bits = 4'(st_r.sl_bits + 4'h1);
                if (!slave_tx && st_r.sl_bits < BYTE_LAST) begin
                    st_nxt.sreg = {st_r.sreg[6:0], sda_in};
                end
                if (slave_tx && st_r.sl_bits == BYTE_LAST && sda_in) begin
                    st_nxt.sl_match = 1'b0; // [R8]
                    st_nxt.rw = 1'b0; // [R8]
                end
            end
            if (scl_fall && st_r.sl_bits == BYTE_LAST) begin
                if (slave_tx) begin
                    st_nxt.sda_low = 1'b0;
                    st_nxt.bf = 1'b0; // [R11]
                    st_nxt.data_addr = 1'b1; // [R6]
                    st_nxt.irq = 1'b1;
                end else if (st_r.sl_match || addr_hit || gc_hit) begin
                    st_nxt.irq = 1'b1; // [R2] [R18] [R24]
                    if (st_r.bf || st_r.ctrl1[C1_OVF]) begin
                        st_nxt.ctrl1[C1_OVF] = st_r.ctrl1[C1_OVF] |
                            st_r.bf; // [R13] [R24]
                    end else begin
                        st_nxt.tbuf = st_r.sreg; // [R2]
                        st_nxt.bf = 1'b1; // [R11]
                        st_nxt.sda_low = 1'b1;
                        st_nxt.data_addr = st_r.sl_match; // [R6]
                        if (!st_r.sl_match) begin
                            st_nxt.rw = st_r.sreg[0] && !gc_hit; // [R8]
                            st_nxt.ua = ten_bit && !st_r.sreg[0]; // [R10]
                            st_nxt.sl_match = !ten_bit || gc_hit ||
                                st_r.sreg[0] ||
                                st_r.sreg[7:3] != TEN_BIT_PREFIX;
                        end
                    end
                end
            end
            if (scl_fall && st_r.sl_bits == ACK_LAST) begin
                st_nxt.sda_low = 1'b0;
                st_nxt.sl_bits = 4'h0;
                if (st_r.sl_match &&
                    (st_r.rw || st_r.ctrl2[C2_START])) begin
                    st_nxt.ctrl1[C1_CKREL] = 1'b0; // [R25]
                end
            end
            if (scl_fall && slave_tx && st_r.sl_bits != 4'h0 &&
                st_r.sl_bits < BYTE_LAST) begin
                st_nxt.sreg = {st_r.sreg[6:0], 1'b0};
            end
            if (slave_tx && st_r.sl_bits < BYTE_LAST &&
                !(scl_fall && st_r.sl_bits == ACK_LAST)) begin
                st_nxt.sda_low = !st_nxt.sreg[7]; // [R26]
            end
            st_nxt.scl_low = st_nxt.sl_match && st_nxt.sl_bits == 4'h0 &&
                !st_nxt.ctrl1[C1_CKREL]; // [R15]
        end else begin
            st_nxt.mst = M_IDLE;
            st_nxt.scl_low = 1'b0;
            st_nxt.sda_low = 1'b0;
        end

        if (!en) begin
            st_nxt.start_seen = 1'b0; // [R7]
            st_nxt.stop_seen = 1'b0; // [R7]
            st_nxt.sl_match = 1'b0;
            st_nxt.sl_bits = 4'h0;
            st_nxt.scl_low = 1'b0; // [R14]
            st_nxt.sda_low = 1'b0; // [R14]
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.ctrl1 <= CTRL_ONE_RESET;
            st_r.ctrl2 <= CTRL_TWO_RESET;
            {st_r.slew, st_r.smb, st_r.data_addr, st_r.stop_seen,
                st_r.start_seen, st_r.rw, st_r.ua, st_r.bf} <= STATUS_RESET;
            st_r.waitreq <= 1'b1;
            st_r.scl_prev <= 1'b1;
            st_r.sda_prev <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign readdata = st_r.rdata;
    assign waitrequest = st_r.waitreq;
    assign scl_out = st_r.pin_level; // [R26]
    assign sda_out = st_r.pin_level; // [R26]
    assign scl_oe = st_r.scl_low;
    assign sda_oe = st_r.sda_low;
    assign port_irq_flag = st_r.irq;
    assign slew_select = st_r.slew; // [R4]
    assign smbus_levels = st_r.smb; // [R5]
    assign pins_to_port = st_r.ctrl1[C1_EN]; // [R14]

endmodule : two_wire_port
`default_nettype wire

//--- sim/two_wire_sva.sv
`default_nettype none
module two_wire_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic waitrequest,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic port_irq_flag,
    input wire logic slew_select,
    input wire logic smbus_levels,
    input wire logic pins_to_port
);
    timeunit 1ns;
    timeprecision 1ps;
    import two_wire_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic wr_ok;
    assign wr_ok = write && !waitrequest && byteenable[0];
    sequence answer_s;
        !waitrequest ##1 waitrequest;
    endsequence
    open_drain_a: assert property (!scl_out && !sda_out)
        else $error("bus line driven high");
    slew_pad_a: assert property (wr_ok && address == OFS_STATUS
        |=> ##1 slew_select == $past(writedata[7], 2))
        else $error("slew output wrong");
    smb_pad_a: assert property (wr_ok && address == OFS_STATUS
        |=> ##1 smbus_levels == $past(writedata[6], 2))
        else $error("level select output wrong");
    enable_pad_a: assert property (wr_ok && address == OFS_CTRL_ONE
        |=> ##1 pins_to_port == $past(writedata[C1_EN], 2))
        else $error("pin enable output wrong");
    pins_free_a: assert property (!pins_to_port && !$past(pins_to_port)
        && !$past(pins_to_port, 2) |-> !scl_oe && !sda_oe)
        else $error("disabled port drives a line");
    scl_rise_a: assert property ($rose(scl_oe) |-> pins_to_port)
        else $error("clock pulled while disabled");
    irq_sticky_a: assert property ($fell(port_irq_flag)
        |-> $past(write) || $past(write, 2))
        else $error("irq flag cleared without write");
    bus_answer_a: assert property ((read || write) && waitrequest
        |=> answer_s)
        else $error("bus answer not one cycle");
    no_spurious_a: assert property ($fell(waitrequest)
        |-> $past(read || write))
        else $error("answer without request");
endmodule : two_wire_sva
bind two_wire_port two_wire_sva two_wire_sva_inst (.clk(clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .waitrequest(waitrequest), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .port_irq_flag(port_irq_flag), .slew_select(slew_select),
    .smbus_levels(smbus_levels), .pins_to_port(pins_to_port));
`default_nettype wire

//--- sim/bus_partner.sv
`default_nettype none
module bus_partner (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_r = 1'b1;
    logic sda_r = 1'b1;
    logic [3:0] cnt_r = 4'h0;
    initial sda_oe = 1'b0;
    // Slave that acknowledges each ninth bit, pulling low only
    always @(posedge clk) begin
        scl_r <= scl;
        sda_r <= sda;
        if (scl && sda_r && !sda) begin
            cnt_r <= 4'h0;
        end else if (scl && !scl_r) begin
            cnt_r <= cnt_r + 4'h1;
        end else if (!scl && scl_r) begin
            sda_oe <= ack_en && cnt_r == 4'h8;
            if (cnt_r == 4'h9) begin
                cnt_r <= 4'h0;
            end
        end
    end
endmodule : bus_partner
`default_nettype wire

//--- sim/two_wire_port_test.sv
`default_nettype none
module two_wire_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import two_wire_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] be = 4'h1;
    logic ack_en = 1'b1;
    logic [31:0] readdata;
    logic waitrequest, scl_out, scl_oe, sda_out, sda_oe, p_sda_oe;
    logic irq, slew, smb, pins, scl_q;
    logic [8:0] rx_sh = 9'h0;
    logic [7:0] q;
    logic [19:0] modes = {MODE_SLAVE7, MODE_SLAVE10, MODE_SLAVE7_SP,
        MODE_SLAVE10_SP, MODE_FW_MASTER};
    int hi_cnt = 0;
    int hi_len = 0;
    int miscompares = 0;
    int cmp_count = 0;
    wire scl = !scl_oe;
    wire sda = !(sda_oe || p_sda_oe);
    always #5 clk = !clk;
    two_wire_port two_wire_port_inst (.clk(clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(be),
        .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .port_irq_flag(irq), .slew_select(slew),
        .smbus_levels(smb), .pins_to_port(pins));
    bus_partner bus_partner_inst (.clk(clk), .scl(scl), .sda(sda),
        .ack_en(ack_en), .sda_oe(p_sda_oe));
    // Bus monitor: bits at clock rise, high time
    always @(posedge clk) begin
        scl_q <= scl;
        hi_cnt <= scl ? hi_cnt + 1 : 0;
        if (!scl && hi_cnt != 0) hi_len <= hi_cnt;
        if (scl && !scl_q) rx_sh <= {rx_sh[7:0], sda};
    end
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= {24'h0, d};
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask : rchk
    task automatic poll(input logic [4:0] a, input logic [7:0] m);
        bus(1'b0, a, 8'h00);
        repeat (300) if ((q & m) !== 8'h00) bus(1'b0, a, 8'h00);
        chk(q & m, 8'h00);
    endtask : poll
    task automatic end_sim();
        $display("Counts: %0d compares, %0d mismatches", cmp_count,
                 miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rchk(OFS_STATUS, STATUS_RESET);
        rchk(OFS_CTRL_ONE, CTRL_ONE_RESET);
        rchk(OFS_CTRL_TWO, CTRL_TWO_RESET);
        rchk(5'h18, 8'h00);
        be <= 4'h0;
        bus(1'b1, OFS_STATUS, 8'hFF);
        rchk(OFS_STATUS, 8'h00);
        be <= 4'h1;
        bus(1'b1, OFS_STATUS, 8'hFF);
        rchk(OFS_STATUS, 8'hC0);
        chk({6'h0, slew, smb}, 8'h03);
        bus(1'b1, OFS_STATUS, 8'h00);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, OFS_CTRL_ONE, {4'h2, modes[4*i +: 4]});
            rchk(OFS_CTRL_ONE, {4'h2, modes[4*i +: 4]});
        end
        $display("register test done");
        bus(1'b1, OFS_ADDRESS, 8'h83);
        rchk(OFS_ADDRESS, 8'h83);
        bus(1'b1, OFS_CTRL_ONE, 8'h28);
        chk({7'h0, pins}, 8'h01);
        bus(1'b1, OFS_CTRL_TWO, 8'h01);
        poll(OFS_CTRL_TWO, 8'h01);
        rchk(OFS_IRQ, 8'h01);
        chk({7'h0, irq}, 8'h01);
        rchk(OFS_STATUS, 8'h08);
        bus(1'b1, OFS_IRQ, 8'h01);
        rchk(OFS_IRQ, 8'h00);
        bus(1'b1, OFS_BUFFER, 8'hA4);
        rchk(OFS_STATUS, 8'h0D);
        bus(1'b1, OFS_BUFFER, 8'h55);
        rchk(OFS_CTRL_ONE, 8'hA8);
        bus(1'b1, OFS_CTRL_TWO, 8'h04);
        rchk(OFS_CTRL_TWO, 8'h00);
        poll(OFS_STATUS, 8'h04);
        rchk(OFS_CTRL_TWO, 8'h00);
        chk(rx_sh[8:1], 8'hA4);
        chk(hi_len[7:0], 8'h08);
        bus(1'b1, OFS_CTRL_ONE, 8'h28);
        rchk(OFS_CTRL_ONE, 8'h28);
        ack_en <= 1'b0;
        bus(1'b1, OFS_BUFFER, 8'h3C);
        poll(OFS_STATUS, 8'h04);
        rchk(OFS_CTRL_TWO, 8'h40);
        bus(1'b1, OFS_CTRL_TWO, 8'h08);
        poll(OFS_CTRL_TWO, 8'h08);
        rchk(OFS_STATUS, 8'h09);
        rchk(OFS_BUFFER, 8'hFF);
        rchk(OFS_STATUS, 8'h08);
        bus(1'b1, OFS_CTRL_TWO, 8'h30);
        poll(OFS_CTRL_TWO, 8'h10);
        chk({7'h0, rx_sh[0]}, 8'h01);
        bus(1'b1, OFS_CTRL_TWO, 8'h04);
        poll(OFS_CTRL_TWO, 8'h04);
        rchk(OFS_STATUS, 8'h10);
        bus(1'b1, OFS_CTRL_ONE, 8'h08);
        rchk(OFS_STATUS, 8'h00);
        chk({7'h0, pins}, 8'h00);
        $display("master test done");
        end_sim();
    end
endmodule : two_wire_port_test
`default_nettype wire
